//--- diag_alarm_pkg.sv
// holds register offsets, field positions, reset values and carrier types for the diagnostic alarm mask block
// assumes the register access port sits on the same clock as the block and carries 7-bit word offsets
package diag_alarm_pkg;

    // ------------------------------------------------------------------
    // register offsets (word index on the device register port)
    // ------------------------------------------------------------------
    localparam logic [6:0] input_zero_window_limits_off = 7'h12;
    localparam logic [6:0] input_one_window_limits_off  = 7'h13;
    localparam logic [6:0] die_temp_window_limits_off   = 7'h14;
    localparam logic [6:0] host_access_mode_select_off  = 7'h16;
    localparam logic [6:0] alarm_fault_mask_off         = 7'h1d;
    localparam logic [6:0] general_event_mask_off       = 7'h1e;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] window_limits_rst = 16'hff00;
    localparam logic [15:0] access_mode_rst   = 16'h0000;
    localparam logic [15:0] alarm_mask_rst    = 16'hefdf;
    localparam logic [15:0] general_mask_rst  = 16'hffff;

    // writable bits; the rest are reserved and read their reset value
    localparam logic [15:0] alarm_mask_wr_bits   = 16'h31ff;
    localparam logic [15:0] general_mask_wr_bits = 16'h00cf;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int hi_field_msb       = 15;
    localparam int hi_field_lsb       = 8;
    localparam int lo_field_msb       = 7;
    localparam int lo_field_lsb       = 0;
    localparam int access_mode_bit    = 0;
    localparam int self_diag_bit      = 13;
    localparam int osc_start_bit      = 12;
    localparam int cfg_checksum_bit   = 8;
    localparam int serial_cksum_bit   = 7;
    localparam int watchdog_bit       = 6;
    localparam int ref_voltage_bit    = 5;
    localparam int in_one_window_bit  = 4;
    localparam int in_zero_window_bit = 3;
    localparam int temp_window_bit    = 2;
    localparam int over_130c_bit      = 1;
    localparam int over_85c_bit       = 0;
    localparam int slew_not_busy_bit  = 7;
    localparam int conv_done_bit      = 6;
    localparam int brk_frame_bit      = 3;
    localparam int brk_parity_bit     = 2;
    localparam int uart_frame_bit     = 1;
    localparam int uart_parity_bit    = 0;

    // widening tails for 8-bit limits
    localparam logic [3:0] hi_tail = 4'hf;
    localparam logic [3:0] lo_tail = 4'h0;

    // ------------------------------------------------------------------
    // fault action codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        act_none  = 2'b00,
        act_clear = 2'b01,
        act_alarm = 2'b10,
        act_hiz   = 2'b11
    } fault_action_type;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        wr;       // write strobe
        logic        rd;       // read strobe
        logic        via_break; // access arrived in break-frame mode
        logic [6:0]  addr;     // word offset
        logic [15:0] wdata;    // write data
    } reg_req_type;

    typedef struct packed {
        logic        valid;    // new result this cycle
        logic [11:0] data;     // 12-bit conversion result
    } conv_type;

endpackage : diag_alarm_pkg

//--- diag_threshold_alarm_mask.sv
// holds threshold registers, access mode, alarm and general masks and summary flags
// assumes status inputs come from same-clock logic; register requests are one-cycle strobes
`timescale 1ns/100ps

module diag_threshold_alarm_mask (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    // register port
    input  wire diag_alarm_pkg::reg_req_type   req,
    output logic [15:0]                        rdata_q,
    output logic                               rvalid_q,
    // conversion results
    input  wire diag_alarm_pkg::conv_type      conv_in_zero,
    input  wire diag_alarm_pkg::conv_type      conv_in_one,
    input  wire diag_alarm_pkg::conv_type      conv_temp,
    // other alarm sources, levels
    input  wire logic                          self_diag_fault,
    input  wire logic                          oscillator_start_fault,
    input  wire logic                          cfg_checksum_fault,
    input  wire logic                          serial_checksum_fault,
    input  wire logic                          watchdog_expiry_fault,
    input  wire logic                          reference_voltage_fault,
    input  wire logic                          over_130c_error,
    input  wire logic                          over_85c_warning,
    // general event sources, levels
    input  wire logic [15:0]                   general_event_flags,
    // single action code for the combined response
    input  wire diag_alarm_pkg::fault_action_type fault_action,
    // results
    output logic [15:0]                        alarm_flags,
    output logic                               alarm_summary_flag,
    output logic                               general_summary_flag,
    output logic                               irq_n,
    output logic                               break_frame_access,
    output logic                               dac_clear,
    output logic                               dac_alarm_volt,
    output logic                               dac_hiz
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [15:0] in_zero_lim_q;  // input zero limits
    logic [15:0] in_one_lim_q;   // input one limits
    logic [15:0] temp_lim_q;     // temperature limits
    logic        mode_q;         // access mode bit
    logic [15:0] alarm_mask_q;   // alarm mask
    logic [15:0] general_mask_q; // general mask
    logic        in_zero_flt;    // window flags
    logic        in_one_flt;
    logic        temp_flt;
    logic        wr_en;          // write allowed in present mode

    // writes to the rest of the map only from the mode that owns it
    assign wr_en = req.wr && (req.via_break == mode_q);
    assign break_frame_access = mode_q;

    // ------------------------------------------------------------------
    // threshold registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            in_zero_lim_q <= diag_alarm_pkg::window_limits_rst;
            in_one_lim_q  <= diag_alarm_pkg::window_limits_rst;
            temp_lim_q    <= diag_alarm_pkg::window_limits_rst;
        end else if (wr_en) begin
            if (req.addr == diag_alarm_pkg::input_zero_window_limits_off) begin
                in_zero_lim_q <= req.wdata;
            end
            if (req.addr == diag_alarm_pkg::input_one_window_limits_off) begin
                in_one_lim_q <= req.wdata;
            end
            if (req.addr == diag_alarm_pkg::die_temp_window_limits_off) begin
                temp_lim_q <= req.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // access mode: only break frames may change it, in either mode
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= diag_alarm_pkg::access_mode_rst[diag_alarm_pkg::access_mode_bit];
        end else if (req.wr && req.via_break
                     && req.addr == diag_alarm_pkg::host_access_mode_select_off) begin
            mode_q <= req.wdata[diag_alarm_pkg::access_mode_bit];
        end
    end

    // ------------------------------------------------------------------
    // masks; reserved bits keep their reset value
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_mask_q   <= diag_alarm_pkg::alarm_mask_rst;
            general_mask_q <= diag_alarm_pkg::general_mask_rst;
        end else if (wr_en) begin
            if (req.addr == diag_alarm_pkg::alarm_fault_mask_off) begin
                alarm_mask_q <= (req.wdata & diag_alarm_pkg::alarm_mask_wr_bits)
                              | (diag_alarm_pkg::alarm_mask_rst & ~diag_alarm_pkg::alarm_mask_wr_bits);
            end
            if (req.addr == diag_alarm_pkg::general_event_mask_off) begin
                general_mask_q <= (req.wdata & diag_alarm_pkg::general_mask_wr_bits)
                                | (diag_alarm_pkg::general_mask_rst & ~diag_alarm_pkg::general_mask_wr_bits);
            end
        end
    end

    // ------------------------------------------------------------------
    // window comparators
    // ------------------------------------------------------------------
    window_compare u_in_zero (
        .clk     (clk),
        .arst_n  (arst_n),
        .limits  (in_zero_lim_q),
        .conv    (conv_in_zero),
        .fault_q (in_zero_flt)
    );

    window_compare u_in_one (
        .clk     (clk),
        .arst_n  (arst_n),
        .limits  (in_one_lim_q),
        .conv    (conv_in_one),
        .fault_q (in_one_flt)
    );

    window_compare u_temp (
        .clk     (clk),
        .arst_n  (arst_n),
        .limits  (temp_lim_q),
        .conv    (conv_temp),
        .fault_q (temp_flt)
    );

    // ------------------------------------------------------------------
    // alarm status vector, never gated by the mask
    // ------------------------------------------------------------------
    always_comb begin
        alarm_flags = 16'h0000;
        alarm_flags[diag_alarm_pkg::self_diag_bit]      = self_diag_fault;
        alarm_flags[diag_alarm_pkg::osc_start_bit]      = oscillator_start_fault;
        alarm_flags[diag_alarm_pkg::cfg_checksum_bit]   = cfg_checksum_fault;
        alarm_flags[diag_alarm_pkg::serial_cksum_bit]   = serial_checksum_fault;
        alarm_flags[diag_alarm_pkg::watchdog_bit]       = watchdog_expiry_fault;
        alarm_flags[diag_alarm_pkg::ref_voltage_bit]    = reference_voltage_fault;
        alarm_flags[diag_alarm_pkg::in_one_window_bit]  = in_one_flt;
        alarm_flags[diag_alarm_pkg::in_zero_window_bit] = in_zero_flt;
        alarm_flags[diag_alarm_pkg::temp_window_bit]    = temp_flt;
        alarm_flags[diag_alarm_pkg::over_130c_bit]      = over_130c_error;
        alarm_flags[diag_alarm_pkg::over_85c_bit]       = over_85c_warning;
    end

    // ------------------------------------------------------------------
    // summaries: a mask bit of one removes its source
    // ------------------------------------------------------------------
    assign alarm_summary_flag   = |(alarm_flags & ~alarm_mask_q);
    assign general_summary_flag = |(general_event_flags & ~general_mask_q & diag_alarm_pkg::general_mask_wr_bits);
    assign irq_n = !(alarm_summary_flag || general_summary_flag);

    // ------------------------------------------------------------------
    // action decode; an unmasked alarm triggers the chosen response
    // ------------------------------------------------------------------
    always_comb begin
        dac_clear      = 1'b0;
        dac_alarm_volt = 1'b0;
        dac_hiz        = 1'b0;
        if (alarm_summary_flag) begin
            unique case (fault_action)
                diag_alarm_pkg::act_none:  begin end
                diag_alarm_pkg::act_clear: dac_clear      = 1'b1;
                diag_alarm_pkg::act_alarm: dac_alarm_volt = 1'b1;
                diag_alarm_pkg::act_hiz:   dac_hiz        = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read port: one-cycle answer, unmapped reads give zero
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= req.rd;
            if (req.rd) begin
                unique case (req.addr)
                    diag_alarm_pkg::input_zero_window_limits_off: rdata_q <= in_zero_lim_q;
                    diag_alarm_pkg::input_one_window_limits_off:  rdata_q <= in_one_lim_q;
                    diag_alarm_pkg::die_temp_window_limits_off:   rdata_q <= temp_lim_q;
                    diag_alarm_pkg::host_access_mode_select_off:  rdata_q <= {15'h0000, mode_q};
                    diag_alarm_pkg::alarm_fault_mask_off:         rdata_q <= alarm_mask_q;
                    diag_alarm_pkg::general_event_mask_off:       rdata_q <= general_mask_q;
                    default:                                      rdata_q <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_mode_spi_locked: assert property (@(posedge clk) disable iff (!arst_n)
        (req.wr && !req.via_break && req.addr == diag_alarm_pkg::host_access_mode_select_off) |=> $stable(mode_q))
        else $error("spi write changed access mode");

    chk_mode_break_write: assert property (@(posedge clk) disable iff (!arst_n)
        (req.wr && req.via_break && req.addr == diag_alarm_pkg::host_access_mode_select_off)
        |=> mode_q == $past(req.wdata[diag_alarm_pkg::access_mode_bit]))
        else $error("break write did not set access mode");

    chk_masked_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        ((alarm_flags & ~alarm_mask_q) == 16'h0000 && !general_summary_flag) |-> irq_n)
        else $error("interrupt raised by masked source");

    chk_unmasked_irq: assert property (@(posedge clk) disable iff (!arst_n)
        (self_diag_fault && !alarm_mask_q[diag_alarm_pkg::self_diag_bit]) |-> (alarm_summary_flag && !irq_n))
        else $error("unmasked self diag missing from summary");

    chk_status_unmasked: assert property (@(posedge clk) disable iff (!arst_n)
        alarm_flags[diag_alarm_pkg::ref_voltage_bit] == reference_voltage_fault
        && alarm_flags[diag_alarm_pkg::osc_start_bit] == oscillator_start_fault)
        else $error("status flag gated by mask");

    chk_reset_masks: assert property (@(posedge clk)
        $rose(arst_n) |-> (alarm_mask_q == diag_alarm_pkg::alarm_mask_rst
                           && general_mask_q == diag_alarm_pkg::general_mask_rst))
        else $error("mask reset value wrong");

    chk_action_hiz: assert property (@(posedge clk) disable iff (!arst_n)
        (alarm_summary_flag && fault_action == diag_alarm_pkg::act_hiz) |-> (dac_hiz && !dac_clear && !dac_alarm_volt))
        else $error("action code not honoured");

    chk_read_latency: assert property (@(posedge clk) disable iff (!arst_n)
        (req.rd && req.addr == diag_alarm_pkg::host_access_mode_select_off) |=> (rvalid_q && rdata_q[15:1] == 15'h0000))
        else $error("mode read answer wrong");

endmodule : diag_threshold_alarm_mask

//--- diag_threshold_alarm_mask_tb.sv
// holds the self-checking bench for the threshold window and mask block
// assumes the host model drives the register port; bench drives status levels
`timescale 1ns/100ps

module diag_threshold_alarm_mask_tb;
    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    logic                             clk, arst_n, rvalid_q, asum, gsum, irq_n, bfa, dcl, dav, dhz;
    diag_alarm_pkg::reg_req_type      req;
    diag_alarm_pkg::conv_type         cz, co, ct;   // per-channel results
    diag_alarm_pkg::fault_action_type act;
    logic [15:0]                      rdata_q, alarm_flags, gen_ev, q, m;
    logic [15:0]                      lim [3];      // limits shadow
    logic [7:0]                       lvl;          // level fault sources
    logic [11:0]                      d;
    logic [2:0]                       wf;           // expected {one,zero,temp}
    int                               err_count, n_tests, seed, i, j, ch, k;
    logic [6:0] offs [7] = '{7'h12, 7'h13, 7'h14, 7'h16, 7'h1d, 7'h1e, 7'h15};
    logic [15:0] rstv [7] = '{16'hff00, 16'hff00, 16'hff00, 16'h0000, 16'hefdf, 16'hffff, 16'h0000};
    int wi [3] = '{1, 2, 0};
    int lb [8] = '{13, 12, 8, 7, 6, 5, 1, 0};
    logic [2:0] actx [4] = '{3'b000, 3'b100, 3'b010, 3'b001};

    // --------------------------------------------------------------
    // instances
    // --------------------------------------------------------------
    host_port_model host_port_model_inst (.clk(clk), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q));
    diag_threshold_alarm_mask diag_threshold_alarm_mask_inst (
        .clk(clk), .arst_n(arst_n), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
        .conv_in_zero(cz), .conv_in_one(co), .conv_temp(ct),
        .self_diag_fault(lvl[0]), .oscillator_start_fault(lvl[1]), .cfg_checksum_fault(lvl[2]),
        .serial_checksum_fault(lvl[3]), .watchdog_expiry_fault(lvl[4]), .reference_voltage_fault(lvl[5]),
        .over_130c_error(lvl[6]), .over_85c_warning(lvl[7]), .general_event_flags(gen_ev),
        .fault_action(act), .alarm_flags(alarm_flags), .alarm_summary_flag(asum),
        .general_summary_flag(gsum), .irq_n(irq_n), .break_frame_access(bfa),
        .dac_clear(dcl), .dac_alarm_volt(dav), .dac_hiz(dhz));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // window fault: equal to a widened limit is still inside
    function automatic logic win(input logic [15:0] l, input logic [11:0] v);
        return (v > {l[15:8], 4'hf}) || (v < {l[7:0], 4'h0});
    endfunction : win

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #2000000;
        err_count++;
        end_sim();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        seed = 18; err_count = 0; n_tests = 0; arst_n = 1'b0; cz = '0; co = '0; ct = '0;
        lvl = '0; gen_ev = '0; act = diag_alarm_pkg::act_none; wf = '0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        gen_ev <= 16'(unsigned'($random(seed)));
        // reset values, unmapped word reads zero
        for (i = 0; i < 7; i++) begin
            host_port_model_inst.rd(offs[i], q);
            chk(q, rstv[i]);
        end
        // every general source masked out of reset
        chk({15'h0, gsum}, 16'h0000);
        @(posedge clk) gen_ev <= '0;
        // mode bit: spi write ignored, break write taken
        host_port_model_inst.wr(7'h16, 16'h0001, 1'b0);
        host_port_model_inst.rd(7'h16, q);
        chk(q, 16'h0000);
        host_port_model_inst.wr(7'h16, 16'h0001, 1'b1);
        host_port_model_inst.rd(7'h16, q);
        chk({q[15:1], bfa}, 16'h0001);
        // in break mode a spi write to limits is refused
        host_port_model_inst.wr(7'h12, 16'h1234, 1'b0);
        host_port_model_inst.rd(7'h12, q);
        chk(q, 16'hff00);
        host_port_model_inst.wr(7'h12, 16'h8010, 1'b1);
        host_port_model_inst.wr(7'h16, 16'h0000, 1'b1);
        host_port_model_inst.rd(7'h12, q);
        chk({q[15:1], q[0] ^ bfa}, 16'h8010);
        lim[0] = 16'h8010; lim[1] = 16'hff00; lim[2] = 16'hff00;
        // unmask everything; reserved bits keep their reset value
        host_port_model_inst.wr(7'h1d, 16'h0000, 1'b0);
        host_port_model_inst.wr(7'h1e, 16'h0000, 1'b0);
        host_port_model_inst.rd(7'h1d, q);
        chk(q, 16'hce00);
        host_port_model_inst.rd(7'h1e, q);
        chk(q, 16'hff30);
        // random results with limit-edge corners among them
        for (i = 0; i < 80; i++) begin
            ch = $unsigned($random(seed)) % 3;
            k = $unsigned($random(seed)) % 6;
            if (i % 8 == 0) begin
                lim[ch] = 16'(unsigned'($random(seed)));
                host_port_model_inst.wr(offs[ch], lim[ch], 1'b0);
            end
            case (k)
                0: d = {lim[ch][15:8], 4'hf};
                1: d = {lim[ch][15:8], 4'hf} + 12'h001;
                2: d = {lim[ch][7:0], 4'h0};
                3: d = {lim[ch][7:0], 4'h0} - 12'h001;
                default: d = 12'(unsigned'($random(seed)));
            endcase
            wf[wi[ch]] = win(lim[ch], d);
            @(posedge clk) begin
                if (ch == 0) cz <= '{1'b1, d};
                if (ch == 1) co <= '{1'b1, d};
                if (ch == 2) ct <= '{1'b1, d};
            end
            @(posedge clk) begin
                cz.valid <= 1'b0; co.valid <= 1'b0; ct.valid <= 1'b0;
            end
            @(negedge clk);
            chk({11'h0, irq_n, asum, alarm_flags[4:2]}, {11'h0, ~|wf, |wf, wf});
        end
        // level sources, fully masked then fully open
        for (k = 0; k < 2; k++) begin
            m = k ? 16'h0000 : 16'hffff;
            host_port_model_inst.wr(7'h1d, m, 1'b0);
            for (j = 0; j < 8; j++) begin
                @(posedge clk) lvl <= 8'h01 << j;
                @(negedge clk);
                chk(alarm_flags & 16'h31e3, 16'h0001 << lb[j]);
                chk({14'h0, irq_n, asum}, k ? 16'h0001 : 16'h0002);
            end
        end
        // every action code while the alarm summary stands
        for (k = 0; k < 4; k++) begin
            @(posedge clk) act <= diag_alarm_pkg::fault_action_type'(k);
            @(negedge clk);
            chk({13'h0, dcl, dav, dhz}, {13'h0, actx[k]});
        end
        // each counted general event, and the reserved ones ignored
        for (j = 0; j < 9; j++) begin
            @(posedge clk) gen_ev <= (j == 8) ? 16'hff30 : 16'h0001 << j;
            @(negedge clk);
            chk({15'h0, gsum}, {15'h0, j != 8 && j != 5 && j != 4});
        end
        end_sim();
    end
endmodule : diag_threshold_alarm_mask_tb

//--- host_port_model.sv
// holds a behavioural host controller that issues register cycles
// assumes the block takes one-cycle wr/rd strobes and answers reads a cycle later
`timescale 1ns/100ps

module host_port_model (
    // clock
    input  wire logic                        clk,
    // register port
    output diag_alarm_pkg::reg_req_type      req,
    input  wire logic [15:0]                 rdata_q,
    input  wire logic                        rvalid_q
);
    // --------------------------------------------------------------
    // bus cycles
    // --------------------------------------------------------------
    initial req = '0;

    // single write; break frames are the only way to move the mode bit
    task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic b);
        @(posedge clk) req <= '{1'b0 + 1'b1, 1'b0, b, a, d};
        // released address, data and break lines show the inverse; both strobes go low
        @(posedge clk) req <= '{1'b0, 1'b0, ~b, ~a, ~d};
    endtask : wr

    // single read; data is only trusted while the valid pulse stands
    task automatic rd(input logic [6:0] a, output logic [15:0] q);
        @(posedge clk) req <= '{1'b0, 1'b1, 1'b0, a, 16'h0000};
        @(posedge clk) req <= '{1'b0, 1'b0, 1'b1, ~a, 16'hffff};
        @(negedge clk) q = (rvalid_q === 1'b1) ? rdata_q : 16'hxxxx;
    endtask : rd
endmodule : host_port_model

//--- window_compare.sv
// holds one channel's threshold window comparator with a result-held fault flag
// assumes results arrive as one-cycle valid pulses on the device clock
`timescale 1ns/100ps

module window_compare (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    // limits and result
    input  wire logic [15:0]               limits,
    input  wire diag_alarm_pkg::conv_type  conv,
    // fault
    output logic                           fault_q
);

    // ------------------------------------------------------------------
    // widening: hi gets ones, lo gets zeros
    // ------------------------------------------------------------------
    logic [11:0] hi_limit; // widened high limit
    logic [11:0] lo_limit; // widened low limit

    assign hi_limit = {limits[diag_alarm_pkg::hi_field_msb:diag_alarm_pkg::hi_field_lsb],
                       diag_alarm_pkg::hi_tail};
    assign lo_limit = {limits[diag_alarm_pkg::lo_field_msb:diag_alarm_pkg::lo_field_lsb],
                       diag_alarm_pkg::lo_tail};

    // ------------------------------------------------------------------
    // flag updates only when a fresh result lands
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_q <= 1'b0;
        end else if (conv.valid) begin
            // strict compares, equal values pass
            fault_q <= (conv.data > hi_limit) || (conv.data < lo_limit);
        end
    end

    // the flag follows the newest result one edge later
    chk_window_update: assert property (@(posedge clk) disable iff (!arst_n)
        conv.valid |=> fault_q == (($past(conv.data) > $past(hi_limit)) || ($past(conv.data) < $past(lo_limit))))
        else $error("window flag does not match last result");

    // without a result the flag holds
    chk_window_hold: assert property (@(posedge clk) disable iff (!arst_n)
        !conv.valid |=> $stable(fault_q))
        else $error("window flag changed without a result");

endmodule : window_compare
